// File: rtl/wdc_aux.v
// wake-up timer, duty cycle sequencer, aux converter and low supply check
//
// Function
// R1 - timer interrupt needs group and timer enable
// R2 - three-bit field picks slow clock source
// R3 - pin function 14 or irq 39 shows expiry
// R4 - armed start flag starts rx/tx on expiry
// R5 - active duration is multiplier*4*2^exp slow ticks
// R6 - host picks duty mode with matching period
// R7 - rx returns to timer state at duration end
// R8 - preamble or sync extends rx duration
// R9 - two durations without packet ends rx
// R10 - tx duty sends buffer, optional irq low
// R11 - after tx return immediately to timer state
// R12 - measure command opcode 0x14, enable, config bytes
// R13 - reply cts then pin, battery, temp, reserved
// R14 - disabled channel skipped and reads zero
// R15 - two-bit select picks pin 0 to 3
// R16 - bit time 12*2^(conversion_time_field+1) clocks, default 0xC
// R17 - low nibble sets pin attenuation range
// R18 - successive approximation, 11-bit results
// R19 - low supply checked at expiry, timer enabled
// R20 - threshold in 50 mV steps from 1.5 V
// R21 - low supply on irq pin or gpio
// R22 - period is mantissa*4*2^exp slow ticks
// R23 - mode 0 off, 1 rx, 2 tx
// R24 - post expiry state ready or sleep
// R25 - duration counter restarts at each expiry
// R26 - cts not ready until conversions done
//
// The register offsets and register access over APB were decided locally.
`include "wdc_map.vh"
module wdc_aux (
  input wire ref_clk,
  input wire nrst,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  output wire pready,
  output reg [31:0] prdata,
  output wire pslverr,
  input wire [7:0] slow_tick_src,
  input wire preamble_det,
  input wire sync_det,
  input wire pkt_done,
  input wire rx_error,
  input wire tx_done,
  output wire rx_en,
  output wire tx_en,
  output reg sleep_state,
  input wire supply_below,
  output reg [4:0] supply_threshold,
  input wire adc_cmp,
  output reg [10:0] adc_dac,
  output reg [1:0] adc_channel,
  output reg [1:0] adc_pin_sel,
  output reg [3:0] adc_atten,
  output reg gpio0_out,
  output reg interrupt_output_pin_n
);
  localparam [2:0] S_WAIT = 3'b001;
  localparam [2:0] S_RX = 3'b010;
  localparam [2:0] S_TX = 3'b100;
  localparam [1:0] A_IDLE = 2'b01;
  localparam [1:0] A_CONV = 2'b10;
  reg [31:0] ctrl_q;
  reg [31:0] timer_q;
  reg [3:0] inten_q;
  reg [31:0] pincfg_q;
  reg [2:0] status_q;
  reg [1:0] start_q;
  reg [7:0] adc_en_q;
  reg [7:0] adc_cfg_q;
  reg [3:0] reply_idx_q;
  reg [2:0] state_q;
  reg [1:0] astate_q;
  reg tick_prev_q;
  reg [39:0] period_cnt_q;
  reg [39:0] dur_cnt_q;
  reg saw_frame_q;
  reg extended_q;
  reg [15:0] res_q [0:2];
  reg [10:0] sar_q;
  reg [3:0] bit_q;
  reg [19:0] step_cnt_q;
  reg [7:0] reply_byte;
  wire timer_on = ctrl_q[`WDC_CTRL_TIMER_EN];
  wire [1:0] mode = ctrl_q[`WDC_CTRL_MODE_LO +: 2];
  wire [2:0] src_sel = ctrl_q[`WDC_CTRL_SRC_LO +: 3];
  wire [4:0] expo = timer_q[`WDC_TIMER_EXP_LO +: 5];
  wire [7:0] mult = timer_q[`WDC_TIMER_MULT_LO +: 8];
  wire [5:0] gpio_func = pincfg_q[5:0];
  wire [5:0] irq_func = pincfg_q[`WDC_PIN_IRQ_LO +: 6];
  // slow source taken as synchronous; one step per rising edge
  wire tick_lvl = slow_tick_src[src_sel]; // R2
  wire tick = tick_lvl & ~tick_prev_q;
  wire [39:0] period_len =
    {22'h000000, timer_q[15:0], 2'h0} << expo; // R22
  wire [39:0] dur_len = {30'h00000000, mult, 2'h0} << expo; // R5
  wire expire = timer_on & tick & (period_cnt_q >= period_len - 40'h1);
  wire dur_end = tick & (dur_cnt_q >= dur_len - 40'h1);
  // apb: zero wait states, reads sampled in the setup phase
  wire setup = psel & ~penable;
  wire access = psel & penable;
  wire mapped = (paddr[1:0] == 2'h0) & (paddr <= `WDC_OFS_START);
  assign pready = 1'b1;
  assign pslverr = access & ~mapped;
  wire wr = access & pwrite & mapped;
  wire rd_stream = access & ~pwrite & (paddr == `WDC_OFS_ADC_STREAM);
  wire [7:0] cfg_eff = (adc_cfg_q == 8'h00) ?
    `WDC_ADC_CFG_DEFAULT : adc_cfg_q; // R16 R17
  wire [3:0] conversion_time_field_eff = cfg_eff[7:4];
  wire [3:0] att_eff = cfg_eff[3:0];
  wire [19:0] step_len = `WDC_ADC_DIV << ({1'b0, conversion_time_field_eff} + 5'h01); // R16
  wire adc_busy = astate_q[1];
  wire cmd_wr = wr & (paddr == `WDC_OFS_ADC_CMD) &
    (pwdata[7:0] == `WDC_MEASURE_OPCODE); // R12
  assign rx_en = state_q[1];
  assign tx_en = state_q[2];

  always @* begin
    case (reply_idx_q)
      4'h0: reply_byte = adc_busy ? `WDC_CTS_BUSY : `WDC_CTS_READY; // R26
      4'h1: reply_byte = res_q[0][15:8]; // R13
      4'h2: reply_byte = res_q[0][7:0];
      4'h3: reply_byte = res_q[1][15:8];
      4'h4: reply_byte = res_q[1][7:0];
      4'h5: reply_byte = res_q[2][15:8];
      4'h6: reply_byte = res_q[2][7:0];
      default: reply_byte = 8'h00;
    endcase
  end

  always @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      prdata <= 32'h0000_0000;
    end else if (setup) begin
      case (paddr)
        `WDC_OFS_CTRL: prdata <= ctrl_q;
        `WDC_OFS_TIMER: prdata <= timer_q;
        `WDC_OFS_INTEN: prdata <= {28'h0000000, inten_q};
        `WDC_OFS_PINCFG: prdata <= pincfg_q;
        `WDC_OFS_STATUS: prdata <= {26'h0000000, state_q, status_q};
        `WDC_OFS_ADC_CMD: prdata <= {7'h00, adc_busy, adc_cfg_q,
          adc_en_q, `WDC_MEASURE_OPCODE};
        `WDC_OFS_ADC_STREAM: prdata <= {24'h000000, reply_byte};
        `WDC_OFS_START: prdata <= {30'h00000000, start_q};
        default: prdata <= 32'h0000_0000;
      endcase
    end
  end

  // configuration registers
  always @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      ctrl_q <= `WDC_CTRL_RST;
      timer_q <= `WDC_TIMER_RST;
      inten_q <= `WDC_INTEN_RST;
      pincfg_q <= `WDC_PINCFG_RST;
    end else if (wr) begin
      if (paddr == `WDC_OFS_CTRL)
        ctrl_q <= {24'h000000, pwdata[7:0]};
      if (paddr == `WDC_OFS_TIMER)
        timer_q <= {pwdata[31:24], 3'h0, pwdata[20:0]};
      if (paddr == `WDC_OFS_INTEN)
        inten_q <= pwdata[3:0];
      if (paddr == `WDC_OFS_PINCFG)
        pincfg_q <= {11'h000, pwdata[20:16], 2'h0, pwdata[13:8],
          2'h0, pwdata[5:0]};
    end
  end

  always @* begin
    supply_threshold = pincfg_q[`WDC_PIN_THR_LO +: 5]; // R20
    sleep_state = ctrl_q[`WDC_CTRL_SLEEP] & state_q[0]; // R24
    adc_pin_sel = adc_en_q[1:0]; // R15
    adc_atten = att_eff; // R17
  end

  // status flags: write one to clear, a same-cycle event wins
  wire lsd_hit = expire & ctrl_q[`WDC_CTRL_LSD_EN] & supply_below; // R19
  wire tx_fin = state_q[2] & tx_done;
  wire [2:0] st_set = {tx_fin, lsd_hit, expire};
  wire [2:0] st_clr = (wr & (paddr == `WDC_OFS_STATUS)) ?
    pwdata[2:0] : 3'h0;
  always @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      status_q <= 3'h0;
    end else begin
      status_q <= (status_q & ~st_clr) | st_set;
    end
  end

  // pin routing and interrupt pin
  wire irq_timer = inten_q[`WDC_INT_GROUP] & inten_q[`WDC_INT_TIMER] &
    status_q[`WDC_ST_EXPIRED]; // R1
  wire irq_lsd = inten_q[`WDC_INT_LSD] &
    status_q[`WDC_ST_LOW_SUPPLY]; // R21
  wire irq_tx = inten_q[`WDC_INT_TXDONE] &
    status_q[`WDC_ST_TX_DONE]; // R10
  always @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      gpio0_out <= 1'b0;
      interrupt_output_pin_n <= 1'b1;
    end else begin
      gpio0_out <= ((gpio_func == `WDC_FUNC_EXPIRY) &
        status_q[`WDC_ST_EXPIRED]) | // R3
        ((gpio_func == `WDC_FUNC_LSD) &
        status_q[`WDC_ST_LOW_SUPPLY]); // R21
      interrupt_output_pin_n <= ~(irq_lsd | irq_tx |
        (irq_timer & (irq_func == `WDC_FUNC_IRQ))); // R1 R3
    end
  end

  // timer period and active duration counters
  always @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      tick_prev_q <= 1'b0;
      period_cnt_q <= 40'h0;
      dur_cnt_q <= 40'h0;
    end else begin
      tick_prev_q <= tick_lvl;
      if (!timer_on || expire)
        period_cnt_q <= 40'h0;
      else if (tick)
        period_cnt_q <= period_cnt_q + 40'h1;
      if (expire || dur_end)
        dur_cnt_q <= 40'h0; // R25
      else if (tick)
        dur_cnt_q <= dur_cnt_q + 40'h1;
    end
  end

  // duty cycle sequencer; mode 0 runs only on an armed start flag
  wire go_rx = (mode == `WDC_MODE_RX) | start_q[0]; // R23
  wire go_tx = (mode == `WDC_MODE_TX) | start_q[1]; // R23
  always @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      state_q <= S_WAIT;
      start_q <= 2'h0;
      saw_frame_q <= 1'b0;
      extended_q <= 1'b0;
    end else begin
      if (wr && paddr == `WDC_OFS_START)
        start_q <= pwdata[1:0];
      case (state_q)
        S_WAIT: begin
          saw_frame_q <= 1'b0;
          extended_q <= 1'b0;
          if (expire && go_rx) begin
            state_q <= S_RX; // R4
            start_q[0] <= 1'b0;
          end else if (expire && go_tx) begin
            state_q <= S_TX; // R4
            start_q[1] <= 1'b0;
          end
        end
        S_RX: begin
          if (preamble_det || sync_det)
            saw_frame_q <= 1'b1; // R8
          if (rx_error)
            saw_frame_q <= 1'b0; // R7
          if (pkt_done)
            state_q <= S_WAIT;
          else if (dur_end) begin
            // one extension only, so a stuck frame costs two durations
            if (saw_frame_q && !extended_q && !rx_error)
              extended_q <= 1'b1; // R8
            else
              state_q <= S_WAIT; // R7 R9
          end
        end
        S_TX: begin
          if (tx_done)
            state_q <= S_WAIT; // R11
        end
        default: state_q <= S_WAIT;
      endcase
    end
  end

  // successive approximation over pin, battery, temperature
  wire [2:0] ch_en = {adc_en_q[4], adc_en_q[3], adc_en_q[2]};
  wire [10:0] trial = sar_q | (11'h400 >> bit_q);
  wire last_bit = (bit_q == 4'hA);
  wire step_done = (step_cnt_q >= step_len - 20'h1);
  reg [1:0] next_ch;
  reg any_next;
  always @* begin
    next_ch = 2'h0;
    any_next = 1'b0;
    if (adc_channel == 2'h0 && ch_en[1]) begin
      next_ch = 2'h1;
      any_next = 1'b1;
    end else if (adc_channel != 2'h2 && ch_en[2]) begin
      next_ch = 2'h2;
      any_next = 1'b1;
    end
  end

  always @* begin
    adc_dac = trial; // R18
  end

  integer i;
  always @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      astate_q <= A_IDLE;
      adc_en_q <= 8'h00;
      adc_cfg_q <= 8'h00;
      adc_channel <= 2'h0;
      sar_q <= 11'h000;
      bit_q <= 4'h0;
      step_cnt_q <= 20'h0;
      reply_idx_q <= 4'h0;
      for (i = 0; i < 3; i = i + 1)
        res_q[i] <= 16'h0000;
    end else begin
      if (rd_stream && (reply_idx_q != 4'h0 || prdata[7:0] == `WDC_CTS_READY))
        reply_idx_q <= (reply_idx_q == `WDC_REPLY_LAST) ?
          4'h0 : reply_idx_q + 4'h1; // R13
      case (astate_q)
        A_IDLE: begin
          if (cmd_wr) begin
            adc_en_q <= {3'h0, pwdata[12:8]}; // R12
            adc_cfg_q <= pwdata[23:16];
            reply_idx_q <= 4'h0;
            for (i = 0; i < 3; i = i + 1)
              res_q[i] <= 16'h0000; // R14
            sar_q <= 11'h000;
            bit_q <= 4'h0;
            step_cnt_q <= 20'h0;
            if (pwdata[10]) begin
              adc_channel <= 2'h0;
              astate_q <= A_CONV;
            end else if (pwdata[11]) begin
              adc_channel <= 2'h1;
              astate_q <= A_CONV;
            end else if (pwdata[12]) begin
              adc_channel <= 2'h2;
              astate_q <= A_CONV;
            end
          end
        end
        A_CONV: begin
          if (!step_done) begin
            step_cnt_q <= step_cnt_q + 20'h1;
          end else begin
            step_cnt_q <= 20'h0;
            if (last_bit) begin
              res_q[adc_channel] <=
                {5'h00, adc_cmp ? trial : sar_q}; // R18
              sar_q <= 11'h000;
              bit_q <= 4'h0;
              adc_channel <= next_ch;
              if (!any_next)
                astate_q <= A_IDLE; // R26
            end else begin
              if (adc_cmp)
                sar_q <= trial;
              bit_q <= bit_q + 4'h1;
            end
          end
        end
        default: astate_q <= A_IDLE;
      endcase
    end
  end
endmodule // wdc_aux

// File: shared/wdc_map.vh
// register map, field positions, reset values and codes of the aux block
`ifndef WDC_MAP_VH
`define WDC_MAP_VH
`define WDC_OFS_CTRL 8'h00
`define WDC_OFS_TIMER 8'h04
`define WDC_OFS_INTEN 8'h08
`define WDC_OFS_PINCFG 8'h0C
`define WDC_OFS_STATUS 8'h10
`define WDC_OFS_ADC_CMD 8'h14
`define WDC_OFS_ADC_STREAM 8'h18
`define WDC_OFS_START 8'h1C
`define WDC_CTRL_TIMER_EN 0
`define WDC_CTRL_LSD_EN 1
`define WDC_CTRL_MODE_LO 2
`define WDC_CTRL_SLEEP 4
`define WDC_CTRL_SRC_LO 5
`define WDC_TIMER_EXP_LO 16
`define WDC_TIMER_MULT_LO 24
`define WDC_INT_GROUP 0
`define WDC_INT_TIMER 1
`define WDC_INT_LSD 2
`define WDC_INT_TXDONE 3
`define WDC_PIN_IRQ_LO 8
`define WDC_PIN_THR_LO 16
`define WDC_ST_EXPIRED 0
`define WDC_ST_LOW_SUPPLY 1
`define WDC_ST_TX_DONE 2
`define WDC_CTRL_RST 32'h0000_0000
`define WDC_TIMER_RST 32'h0001_0001
`define WDC_INTEN_RST 4'h0
`define WDC_PINCFG_RST 32'h0000_0000
`define WDC_MODE_OFF 2'h0
`define WDC_MODE_RX 2'h1
`define WDC_MODE_TX 2'h2
`define WDC_FUNC_EXPIRY 6'h0E
`define WDC_FUNC_IRQ 6'h27
`define WDC_FUNC_LSD 6'h0F
`define WDC_MEASURE_OPCODE 8'h14
`define WDC_ADC_CFG_DEFAULT 8'hCC
`define WDC_ADC_DIV 20'h0000C
`define WDC_CTS_READY 8'hFF
`define WDC_CTS_BUSY 8'h00
`define WDC_REPLY_LAST 4'h8
`endif

// File: testbench/wdc_aux_assertions.sv
// port-level checks on the aux block
module wdc_aux_chk (
  input logic ref_clk,
  input logic nrst,
  input logic psel,
  input logic penable,
  input logic pwrite,
  input logic [7:0] paddr,
  input logic pslverr,
  input logic rx_en,
  input logic tx_en,
  input logic sleep_state,
  input logic pkt_done,
  input logic tx_done,
  input logic [4:0] supply_threshold,
  input logic [1:0] adc_pin_sel,
  input logic [3:0] adc_atten
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!nrst);
  logic wr;
  assign wr = psel && penable && pwrite;
  one_mode_a: assert property (!(rx_en && tx_en))
    else $error("rx and tx active together");
  sleep_idle_a: assert property (sleep_state |-> !rx_en && !tx_en)
    else $error("sleep while radio active");
  tx_return_a: assert property (tx_en && tx_done |=> !tx_en)
    else $error("tx kept after done");
  rx_packet_a: assert property (rx_en && pkt_done |=> !rx_en)
    else $error("rx kept after packet");
  thresh_hold_a: assert property (
    !(wr && paddr == 8'h0C) |=> $stable(supply_threshold))
    else $error("threshold moved without write");
  pin_hold_a: assert property (
    !(wr && paddr == 8'h14) |=> $stable(adc_pin_sel))
    else $error("pin select moved without command");
  atten_hold_a: assert property (
    !(wr && paddr == 8'h14) |=> $stable(adc_atten))
    else $error("attenuation moved without command");
  unmapped_err_a: assert property (
    psel && penable && paddr > 8'h1C |-> pslverr)
    else $error("no error on unmapped access");
  cover property ($rose(rx_en));
  cover property ($rose(tx_en));
  cover property (psel && penable && pslverr);
endmodule // wdc_aux_chk

bind wdc_aux wdc_aux_chk i_wdc_aux_chk (.ref_clk, .nrst, .psel, .penable,
  .pwrite, .paddr, .pslverr, .rx_en, .tx_en, .sleep_state, .pkt_done,
  .tx_done, .supply_threshold, .adc_pin_sel, .adc_atten);

// File: testbench/wdc_far_model.sv
// stand-in for radio status, slow clocks and analog inputs
module wdc_far_model #(
  parameter logic [10:0] LV_PIN = 11'h100,
  parameter logic [10:0] LV_BAT = 11'h200,
  parameter logic [10:0] LV_TMP = 11'h300
) (
  input logic ref_clk,
  input logic rx_en,
  input logic tx_en,
  input logic [2:0] rx_kind,
  input logic [10:0] adc_dac,
  input logic [1:0] adc_channel,
  output logic [7:0] slow_tick_src,
  output logic preamble_det,
  output logic sync_det,
  output logic pkt_done,
  output logic rx_error,
  output logic tx_done,
  output logic adc_cmp
);
  logic [9:0] cnt = '0;
  logic [7:0] c = '0;
  always @(posedge ref_clk) begin
    cnt <= cnt + 10'h001;
    c <= (rx_en | tx_en) ? c + 8'h01 : 8'h00;
  end
  // sources far faster than 32 kHz so periods stay short; bit k: 8<<k
  assign slow_tick_src = cnt[9:2];
  // kind 1 preamble, 2 packet, 3 sync only, 4 preamble then error
  assign preamble_det = rx_en && (rx_kind inside {3'h1, 3'h2, 3'h4}) &&
    c == 8'h03;
  assign pkt_done = rx_en && rx_kind == 3'h2 && c == 8'h0C;
  assign tx_done = tx_en && c == 8'h06;
  assign sync_det = rx_en && rx_kind == 3'h3 && c == 8'h03;
  assign rx_error = rx_en && rx_kind == 3'h4 && c == 8'h10;
  // ideal comparator: sar settles exactly on the level
  assign adc_cmp = (adc_channel == 2'h0 ? LV_PIN :
    adc_channel == 2'h1 ? LV_BAT : LV_TMP) >= adc_dac;
endmodule // wdc_far_model

// File: testbench/testbench.sv
// self-checking bench for the aux block
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [10:0] LP = 11'h3A1, LB = 11'h2A5, LT = 11'h5C3;
  logic ref_clk = 0, nrst = 0, psel = 0, penable = 0, pwrite = 0;
  logic supply_below = 0, serr;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, rdat;
  logic [2:0] rx_kind = 3'h0;
  wire pready, pslverr, preamble_det, sync_det, pkt_done, rx_error;
  wire tx_done, rx_en, tx_en, sleep_state, adc_cmp, gpio0_out;
  wire interrupt_output_pin_n;
  wire [31:0] prdata;
  wire [7:0] slow_tick_src;
  wire [4:0] supply_threshold;
  wire [10:0] adc_dac;
  wire [1:0] adc_channel, adc_pin_sel;
  wire [3:0] adc_atten;
  int mismatches = 0, n_checks = 0, cyc = 0, n;
  time t0 = 0, t1 = 0;
  wdc_aux i_wdc_aux (.ref_clk, .nrst, .psel, .penable, .pwrite, .paddr,
    .pwdata, .pready, .prdata, .pslverr, .slow_tick_src, .preamble_det,
    .sync_det, .pkt_done, .rx_error, .tx_done, .rx_en, .tx_en,
    .sleep_state, .supply_below, .supply_threshold, .adc_cmp, .adc_dac,
    .adc_channel, .adc_pin_sel, .adc_atten, .gpio0_out,
    .interrupt_output_pin_n);
  wdc_far_model #(.LV_PIN(LP), .LV_BAT(LB), .LV_TMP(LT)) i_wdc_far_model (
    .ref_clk, .rx_en, .tx_en, .rx_kind, .adc_dac, .adc_channel,
    .slow_tick_src, .preamble_det, .sync_det, .pkt_done, .rx_error,
    .tx_done, .adc_cmp);
  initial forever #5 ref_clk = ~ref_clk;
  task conclude;
    if (mismatches == 0 && n_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 40000) begin
      mismatches++;
      conclude();
    end
  end
  task chk(input logic [31:0] s, e);
    n_checks++;
    if (s !== e) begin
      mismatches++;
      $display("unexpected at %0t: seen %h expected %h", $time, s, e);
    end
  endtask
  task near(input int v, e);
    chk(v >= e - 1 && v <= e + 1, 1);
  endtask
  task xf(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1;
    @(posedge ref_clk);
    while (pready !== 1'b1) @(posedge ref_clk);
    rdat = prdata;
    serr = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  // sampled on the falling edge, clear of the flops' updates
  task rise;
    while (rx_en | tx_en) @(negedge ref_clk);
    while (!(rx_en | tx_en)) @(negedge ref_clk);
    t1 = t0;
    t0 = $time;
  endtask
  task len;
    n = 0;
    while (rx_en | tx_en) begin
      n++;
      @(negedge ref_clk);
    end
  endtask
  task t_regs;
    xf(0, 8'h04, 0);
    chk(rdat, 32'h0001_0001);
    xf(0, 8'h20, 0);
    chk({serr, rdat[30:0]}, 32'h8000_0000);
  endtask
  task t_timer;
    xf(1, 8'h0C, 32'h0005_270E);
    xf(1, 8'h04, 32'h0100_0004);
    chk(supply_threshold, 32'h5);
    supply_below <= 1;
    xf(1, 8'h00, 32'h0000_0007);
    rise;
    len;
    near(n, 32);
    rise;
    chk(32'((t0 - t1) / 10), 128);
    xf(0, 8'h10, 0);
    chk(rdat[1:0], 2'b11);
    chk({gpio0_out, interrupt_output_pin_n}, 2'b11);
    xf(1, 8'h08, 32'h3);
    rise;
    repeat (2) @(negedge ref_clk);
    chk(interrupt_output_pin_n, 0);
    xf(1, 8'h10, 32'h7);
    repeat (2) @(negedge ref_clk);
    chk(interrupt_output_pin_n, 1);
    xf(1, 8'h00, 32'h0000_0037);
    rise;
    rise;
    chk(32'((t0 - t1) / 10), 256);
    len;
    chk(sleep_state, 1);
  endtask
  task t_rx;
    int e[5];
    e = '{32, 64, 13, 64, 32};
    xf(1, 8'h00, 32'h0000_0007);
    for (int k = 0; k < 5; k++) begin
      rx_kind <= k[2:0];
      rise;
      len;
      near(n, e[k]);
    end
  endtask
  task t_tx;
    xf(1, 8'h00, 32'h0000_0001);
    xf(1, 8'h1C, 32'h1);
    rise;
    chk(rx_en, 1);
    xf(1, 8'h00, 32'h0000_0009);
    rise;
    len;
    near(n, 7);
    xf(0, 8'h10, 0);
    chk(rdat[2], 1);
  endtask
  task t_adc(input logic [7:0] en, cfg, input logic [10:0] p, b, t);
    logic [7:0] e[8];
    e = '{{5'h0, p[10:8]}, p[7:0], {5'h0, b[10:8]}, b[7:0],
      {5'h0, t[10:8]}, t[7:0], 8'h00, 8'h00};
    xf(1, 8'h14, {8'h00, cfg, en, 8'h15});
    xf(0, 8'h14, 0);
    chk(rdat[24], 0);
    xf(1, 8'h14, {8'h00, cfg, en, 8'h14});
    @(negedge ref_clk);
    chk({adc_pin_sel, adc_atten}, {en[1:0], cfg[3:0]});
    xf(0, 8'h18, 0);
    chk(rdat[7:0], 8'h00);
    n = 0;
    while (rdat[7:0] !== 8'hFF && n++ < 900) xf(0, 8'h18, 0);
    chk(rdat[7:0], 8'hFF);
    for (int i = 0; i < 8; i++) begin
      xf(0, 8'h18, 0);
      chk(rdat[7:0], e[i]);
    end
  endtask
  initial begin
    repeat (20) @(posedge ref_clk);
    nrst <= 1;
    t_regs;
    t_timer;
    t_rx;
    t_tx;
    t_adc(8'h18, 8'h04, 11'h0, LB, LT);
    t_adc(8'h06, 8'h08, LP, 11'h0, 11'h0);
    conclude;
  end
endmodule // testbench
